/* bench/sls_loop_primary.sv */
// loop primary model: bit clock, receive line and capture of the echo
`timescale 1ns/1ps
module sls_loop_primary
(
    input wire logic sys_clk, // system clock for pacing
    input wire logic tx_pin_ff, // station transmit line
    output logic line_clk, // bit clock, still between frames
    output logic rx_pin, // line into the station
    output logic [7:0] heard // last eight echoed bits, newest at 7
);
    // idle: clock parked low, marking line
    initial
    begin
        line_clk = 1'b0;
        rx_pin = 1'b1;
        heard = 8'h00;
    end
    // hold the line at a level without clocking
    task automatic hold(input logic v);
        rx_pin = v;
    endtask
    // send n bits lsb first, one bit per 16 system clocks
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            #1 rx_pin = b[i];
            repeat (4) @(posedge sys_clk);
            #1 line_clk = 1'b1;
            repeat (8) @(posedge sys_clk);
            #1 line_clk = 1'b0;
            heard = {tx_pin_ff, heard[7:1]};
            repeat (3) @(posedge sys_clk);
        end
        // return off the edge so callers sample settled values
        #1;
    endtask
endmodule

/* bench/sls_loop_station_bench.sv */
// self-checking bench of the loop-mode secondary station
`timescale 1ns/1ps
module sls_loop_station_bench
    import sls_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] ctl = 8'h00;
    logic clr_break = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic chan_b = 1'b0;
    logic [7:0] vec_base = 8'hA5;
    logic [2:0] vec_status = 3'h6;
    logic [7:0] pend_in = 8'h3C;
    logic fc_en = 1'b0;
    logic idle_flag = 1'b1;
    logic line_clk, rx_pin, tx_pin, tx_ready;
    logic [7:0] sts, ext, vec, pend, fcl, fcs, heard;
    int bad_count = 0;
    int checks_done = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    sls_loop_station dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .line_clk(line_clk), .rx_pin(rx_pin), .tx_pin_ff(tx_pin),
        .misc_control_reg(ctl), .idle_flag(idle_flag), .nrzi_en(1'b0),
        .clr_break(clr_break), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready_ff(tx_ready), .misc_status_reg_ff(sts),
        .buffer_ext_status_reg_ff(ext), .chan_b(chan_b),
        .vec_base(vec_base), .vec_status(vec_status), .pend_in(pend_in),
        .fc_en(fc_en), .vector_read_reg_ff(vec),
        .pending_bits_reg_ff(pend), .frame_count_low_reg_ff(fcl),
        .frame_count_status_reg_ff(fcs));

    sls_loop_primary lp (.sys_clk(sys_clk), .tx_pin_ff(tx_pin),
        .line_clk(line_clk), .rx_pin(rx_pin), .heard(heard));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // offer a byte until taken; valid is left high for back to back
    task automatic push(input logic [7:0] d);
        tx_data = d;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1)
            tick(1);
        tick(1);
    endtask
    task automatic clear_break();
        clr_break = 1'b1;
        tick(1);
        clr_break = 1'b0;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_reset_reads();
        chk(sts, 8'h00, "status after reset");
        chk({7'h00, tx_pin}, 8'h01, "line idle");
        for (int b = 0; b < 2; b++)
        begin
            chan_b = b[0];
            tick(2);
            chk(vec, b ? {vec_base[7:4], vec_status, vec_base[0]} :
                vec_base, "vector");
            chk(pend, b ? 8'h00 : pend_in, "pending");
            chk(fcl, 8'h00, "count low off");
            chk(fcs, 8'h00, "count status off");
        end
    endtask
    task automatic test_pass();
        lp.hold(1'b0);
        tick(6);
        chk({7'h00, tx_pin}, 8'h01, "off loop no repeat");
        ctl[CTL_LOOP_SEL] = 1'b1;
        tick(6);
        chk({7'h00, tx_pin}, 8'h00, "pass low");
        lp.hold(1'b1);
        tick(6);
        chk({7'h00, tx_pin}, 8'h01, "pass high");
        lp.send(8'hFF, 7);
        tick(2);
        chk(sts, 8'h00, "still pass without go active");
        chk({7'h00, tx_pin}, 8'h01, "pass follows ones");
    endtask
    task automatic test_on_loop();
        ctl[CTL_GO_ACTIVE] = 1'b1;
        lp.send(8'hFF, 7);
        tick(2);
        chk(sts, 8'h02, "on loop");
        chk(ext, 8'h90, "break and hunt");
        lp.send(8'hFE, 8);
        tick(2);
        chk(sts, 8'h02, "no send before flag");
        ctl[CTL_GO_ACTIVE] = 1'b0;
        clear_break();
        idle_flag = 1'b0;
        lp.send(8'h7E, 8);
        tick(2);
        chk(heard, 8'hFD, "one-bit delay");
        chk(ext, 8'h00, "flag ends hunt");
    endtask
    task automatic test_frame();
        ctl[CTL_GO_ACTIVE] = 1'b1;
        fc_en = 1'b1;
        lp.send(8'hFF, 7);
        tick(2);
        chk(sts, 8'h12, "loop sending");
        chk(ext, 8'h90, "poll status");
        chk({1'b0, heard[7:1]}, 8'h7E, "poll made flag");
        ctl[CTL_GO_ACTIVE] = 1'b0;
        push(8'h12);
        push(8'h34);
        tx_valid = 1'b0;
        tick(1);
        chk({7'h00, tx_ready}, 8'h00, "buffer full");
        lp.send(8'hFF, 8);
        chk(heard, FLAG_PAT, "single opening flag");
        chk(fcl, 8'h01, "count low");
        chk(fcs, 8'h80, "count status");
        lp.send(8'hFF, 8);
        chk(heard, 8'h12, "first byte");
        lp.send(8'hFF, 8);
        chk(heard, 8'h34, "second byte");
        chk({7'h00, tx_ready}, 8'h01, "buffer drained");
        lp.send(8'hFF, 8);
        chk(heard, FLAG_PAT, "closing flag");
        lp.send(8'h02, 2);
        tick(2);
        chk(sts, 8'h02, "sending ends");
        chk({6'h00, heard[7:6]}, 8'h01, "back to delay");
        chk(fcl, 8'h02, "count low at end");
        chk(fcs, 8'h00, "count status closed");
    endtask
    task automatic test_leave();
        ctl[CTL_LOOP_SEL] = 1'b0;
        clear_break();
        lp.send(8'hFF, 7);
        tick(2);
        chk(sts, 8'h00, "off loop after ones");
        chk(ext, 8'h90, "exit sets break");
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial
    begin
        tick(12);
        sys_rst = 1'b0;
        tick(2);
        test_reset_reads();
        test_pass();
        test_on_loop();
        test_frame();
        test_leave();
        stop_test();
    end
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        bad_count++;
        stop_test();
    end
endmodule

/* hdl/sls_loop_station.sv */
// loop-mode secondary station: repeater, poll detection and frame sender
`timescale 1ns/1ps
module sls_loop_station
    import sls_pkg::*;
(
    input wire logic sys_clk, // 100 MHz system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic line_clk, // loop bit clock pin
    input wire logic rx_pin, // loop receive line pin
    output logic tx_pin_ff, // loop transmit line
    input wire logic [7:0] misc_control_reg, // loop control byte
    input wire logic idle_flag, // off-loop idle: 1 flags, or zeros if a loop send left the shifter empty; 0 marks
    input wire logic nrzi_en, // nrzi line coding
    input wire logic clr_break, // pulse: clear break/abort bit
    input wire logic [7:0] tx_data, // transmit byte
    input wire logic tx_valid, // transmit byte offered
    output logic tx_ready_ff, // buffer can take a byte
    output logic [7:0] misc_status_reg_ff, // loop status byte
    output logic [7:0] buffer_ext_status_reg_ff, // break and hunt
    input wire logic chan_b, // read through second channel
    input wire logic [7:0] vec_base, // stored interrupt vector
    input wire logic [2:0] vec_status, // status code for vector
    input wire logic [7:0] pend_in, // interrupt pending bits
    input wire logic fc_en, // frame byte-count feature enable
    output logic [7:0] vector_read_reg_ff, // vector read value
    output logic [7:0] pending_bits_reg_ff, // pending bits read value
    output logic [7:0] frame_count_low_reg_ff, // byte count low
    output logic [7:0] frame_count_status_reg_ff // count high and status
);
    // ************************************************************
    // pin synchronisers and bit strobe
    // ************************************************************
    logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
    logic rx_s1_ff, rx_s2_ff;
    logic strobe;

    // two stages per pin, third stage only for the edge detect
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end
        else
        begin
            clk_s1_ff <= line_clk;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            rx_s1_ff <= rx_pin;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    assign strobe = clk_s2_ff & ~clk_s3_ff; // rising line clock

    // ************************************************************
    // two-entry transmit buffer
    // ************************************************************
    logic [7:0] buf_ff [2];
    logic [1:0] cnt_ff, nxt_cnt;
    logic wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic nxt_ready, push, pop, buf_valid;

    assign push = tx_valid & tx_ready_ff;
    assign buf_valid = (cnt_ff != 2'h0);

    // pointer and fill count update; ready follows the next count
    always_comb
    begin
        nxt_wr = wr_ff ^ push;
        nxt_rd = rd_ff ^ pop;
        nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
        nxt_ready = (nxt_cnt != 2'h2);
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            cnt_ff <= 2'h0;
            tx_ready_ff <= 1'b0;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            tx_ready_ff <= nxt_ready;
        end
        if (push)
        begin
            buf_ff[wr_ff] <= tx_data;
        end
    end

    // ************************************************************
    // loop sequencer and transmit shifter
    // ************************************************************
    sls_state_t state_ff, nxt_state;
    sls_stat_t stat_ff, nxt_stat;
    logic [7:0] hist_ff, nxt_hist, sh_ff, nxt_sh;
    logic [2:0] bcnt_ff, nxt_bcnt, ones_ff, nxt_ones;
    logic dly_ff, nxt_dly, nxt_tx;
    logic stuff_ff, nxt_stuff, frame_ff, nxt_frame;
    logic [13:0] fcnt_ff, nxt_fcnt;
    logic loop_sel, go_active, rx_dec, seven, brk_set, bit_out, adv;

    assign loop_sel = misc_control_reg[CTL_LOOP_SEL];
    assign go_active = misc_control_reg[CTL_GO_ACTIVE];
    // nrzi: a zero is a level change against the previous bit
    assign rx_dec = nrzi_en ? ~(rx_s2_ff ^ dly_ff) : rx_s2_ff;
    assign nxt_hist = strobe ? {hist_ff[6:0], rx_dec} : hist_ff;
    assign seven = (nxt_hist[6:0] == SEVEN_ONES);

    // next state of the whole loop sequence
    always_comb
    begin
        nxt_state = state_ff;
        nxt_stat = stat_ff;
        nxt_sh = sh_ff;
        nxt_bcnt = bcnt_ff;
        nxt_ones = ones_ff;
        nxt_stuff = stuff_ff;
        nxt_frame = frame_ff;
        nxt_fcnt = fcnt_ff;
        nxt_tx = tx_pin_ff;
        nxt_dly = strobe ? rx_s2_ff : dly_ff; // one-bit delay stage
        brk_set = 1'b0;
        pop = 1'b0;
        bit_out = 1'b1;
        adv = 1'b0;
        unique case (state_ff)
            ST_OFF:
            begin
                if (loop_sel)
                begin
                    nxt_state = ST_PASS;
                    nxt_sh = FLAG_PAT;
                    nxt_bcnt = 3'h0;
                    nxt_ones = 3'h0;
                    nxt_stuff = 1'b0;
                end
                else if (strobe)
                begin
                    nxt_tx = idle_flag ? sh_ff[0] : 1'b1;
                    nxt_sh = {sh_ff[0], sh_ff[7:1]};
                end
            end
            ST_PASS:
            begin
                nxt_tx = rx_s2_ff;
                if (!loop_sel)
                begin
                    nxt_state = ST_OFF;
                end
                else if (go_active && strobe && seven)
                begin
                    nxt_state = ST_WAIT_FLAG;
                    brk_set = 1'b1;
                    nxt_stat.on_loop = 1'b1;
                    nxt_stat.hunt = 1'b1;
                end
            end
            ST_WAIT_FLAG:
            begin
                if (strobe)
                begin
                    nxt_tx = dly_ff;
                    if (!loop_sel && seven)
                    begin
                        nxt_state = ST_OFF;
                        brk_set = 1'b1;
                        nxt_stat.on_loop = 1'b0;
                    end
                    else if (nxt_hist == FLAG_PAT)
                    begin
                        nxt_state = ST_WAIT_EOP;
                        nxt_stat.hunt = 1'b0;
                    end
                end
            end
            ST_WAIT_EOP:
            begin
                if (strobe)
                begin
                    nxt_tx = dly_ff;
                    if (nxt_hist == EOP_PAT)
                    begin
                        brk_set = 1'b1;
                        nxt_stat.hunt = 1'b1;
                        nxt_state = ST_WAIT_FLAG;
                        if (!loop_sel)
                        begin
                            nxt_state = ST_OFF;
                            nxt_stat.on_loop = 1'b0;
                        end
                        else if (go_active)
                        begin
                            nxt_state = ST_SEND;
                            nxt_stat.loop_sending = 1'b1;
                            // sixth one still goes out; the flag's leading
                            // zero replaces the seventh, closing a flag
                            nxt_sh = FLAG_PAT;
                            nxt_bcnt = 3'h0;
                            nxt_ones = 3'h0;
                            nxt_stuff = 1'b0;
                            nxt_frame = 1'b0;
                            nxt_fcnt = FCNT_RST;
                        end
                    end
                end
            end
            ST_SEND:
            begin
                if (strobe)
                begin
                    if (stuff_ff && ones_ff == STUFF_ONES)
                    begin
                        bit_out = 1'b0; // inserted zero
                        nxt_ones = 3'h0;
                    end
                    else
                    begin
                        bit_out = sh_ff[0];
                        adv = 1'b1;
                        nxt_sh = {1'b0, sh_ff[7:1]};
                        nxt_bcnt = bcnt_ff + 3'h1;
                        nxt_ones = sh_ff[0] ? ones_ff + 3'h1 : 3'h0;
                    end
                    nxt_tx = nrzi_en ? (bit_out ? tx_pin_ff : ~tx_pin_ff)
                                     : bit_out;
                    // underrun and idle settings play no part here
                    if (adv && bcnt_ff == LAST_BIT)
                    begin
                        nxt_ones = 3'h0;
                        if (buf_valid)
                        begin
                            nxt_sh = buf_ff[rd_ff];
                            pop = 1'b1;
                            nxt_stuff = 1'b1;
                            nxt_frame = 1'b1;
                            nxt_fcnt = fcnt_ff + 14'h0001;
                        end
                        else if (frame_ff)
                        begin
                            nxt_sh = FLAG_PAT;
                            nxt_stuff = 1'b0;
                            nxt_frame = 1'b0;
                        end
                        else if (go_active && loop_sel)
                        begin
                            nxt_sh = FLAG_PAT;
                            nxt_stuff = 1'b0;
                        end
                        else
                        begin
                            nxt_stat.loop_sending = 1'b0;
                            nxt_state = (nrzi_en && nxt_tx != rx_s2_ff)
                                        ? ST_PAD : ST_WAIT_FLAG;
                        end
                    end
                end
            end
            ST_PAD:
            begin
                if (strobe)
                begin
                    nxt_tx = ~tx_pin_ff; // extra nrzi zero
                    nxt_state = ST_WAIT_FLAG;
                end
            end
            default:
            begin
                nxt_state = ST_OFF;
            end
        endcase
        // hardware set wins over a software clear
        nxt_stat.break_abort = brk_set | (stat_ff.break_abort & ~clr_break);
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_OFF;
            stat_ff <= STAT_RST;
            hist_ff <= REG_RST;
            sh_ff <= FLAG_PAT;
            bcnt_ff <= 3'h0;
            ones_ff <= 3'h0;
            dly_ff <= 1'b1;
            stuff_ff <= 1'b0;
            frame_ff <= 1'b0;
            fcnt_ff <= FCNT_RST;
            tx_pin_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            stat_ff <= nxt_stat;
            hist_ff <= nxt_hist;
            sh_ff <= nxt_sh;
            bcnt_ff <= nxt_bcnt;
            ones_ff <= nxt_ones;
            dly_ff <= nxt_dly;
            stuff_ff <= nxt_stuff;
            frame_ff <= nxt_frame;
            fcnt_ff <= nxt_fcnt;
            tx_pin_ff <= nxt_tx;
        end
    end

    // ************************************************************
    // read-side registers
    // ************************************************************
    logic [7:0] nxt_misc, nxt_ext, nxt_vec, nxt_pend, nxt_fcl, nxt_fcs;

    // unimplemented bits read zero
    always_comb
    begin
        nxt_misc = REG_RST;
        nxt_misc[STS_ON_LOOP] = nxt_stat.on_loop;
        nxt_misc[STS_LOOP_SEND] = nxt_stat.loop_sending;
        nxt_ext = REG_RST;
        nxt_ext[EXT_BREAK] = nxt_stat.break_abort;
        nxt_ext[EXT_HUNT] = nxt_stat.hunt;
        nxt_vec = vec_base;
        if (chan_b)
        begin
            nxt_vec[VEC_STS_LO +: 3] = vec_status;
        end
        nxt_pend = chan_b ? REG_RST : pend_in;
        nxt_fcl = fc_en ? nxt_fcnt[7:0] : REG_RST;
        nxt_fcs = fc_en ? {nxt_frame, 1'b0, nxt_fcnt[13:8]}
                        : REG_RST;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            misc_status_reg_ff <= REG_RST;
            buffer_ext_status_reg_ff <= REG_RST;
            vector_read_reg_ff <= REG_RST;
            pending_bits_reg_ff <= REG_RST;
            frame_count_low_reg_ff <= REG_RST;
            frame_count_status_reg_ff <= REG_RST;
        end
        else
        begin
            misc_status_reg_ff <= nxt_misc;
            buffer_ext_status_reg_ff <= nxt_ext;
            vector_read_reg_ff <= nxt_vec;
            pending_bits_reg_ff <= nxt_pend;
            frame_count_low_reg_ff <= nxt_fcl;
            frame_count_status_reg_ff <= nxt_fcs;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    pass_through_a: assert property (
        state_ff == ST_PASS |=> tx_pin_ff == $past(rx_s2_ff))
        else $error("pass-through does not follow the receive line");
    flag_preload_a: assert property (
        state_ff == ST_OFF && loop_sel |=> state_ff == ST_PASS
        && sh_ff == FLAG_PAT)
        else $error("flag not preloaded on loop select");
    go_on_loop_a: assert property (
        state_ff == ST_PASS && loop_sel && go_active && strobe && seven
        |=> stat_ff.on_loop && stat_ff.hunt && stat_ff.break_abort)
        else $error("seven ones did not put the station on the loop");
    send_cause_a: assert property (
        $rose(stat_ff.loop_sending) |-> $past(state_ff) == ST_WAIT_EOP
        && $past(nxt_hist) == EOP_PAT)
        else $error("sending began without a flag and end of poll");
    eop_convert_a: assert property (
        state_ff == ST_WAIT_EOP && strobe && nxt_hist == EOP_PAT
        && loop_sel && go_active
        |=> state_ff == ST_SEND && sh_ff == FLAG_PAT
        && stat_ff.loop_sending && tx_pin_ff == $past(dly_ff))
        else $error("end of poll not turned into a flag");
    send_end_a: assert property (
        $fell(stat_ff.loop_sending) |-> !$past(frame_ff) && !$past(buf_valid)
        && (state_ff == ST_WAIT_FLAG || state_ff == ST_PAD))
        else $error("loop sending dropped before the closing flag");
    status_map_a: assert property (
        misc_status_reg_ff == {3'h0, stat_ff.loop_sending, 2'h0,
        stat_ff.on_loop, 1'b0})
        else $error("status byte does not match loop state");
    break_wins_a: assert property (
        brk_set && clr_break |=> stat_ff.break_abort)
        else $error("break event lost to a clear");
    vector_plain_a: assert property (
        !chan_b |=> vector_read_reg_ff == $past(vec_base))
        else $error("first channel vector was modified");
    count_gate_a: assert property (
        !fc_en |=> frame_count_low_reg_ff == 8'h00
        && frame_count_status_reg_ff == 8'h00)
        else $error("byte count readable while disabled");
    buffer_full_a: assert property (
        cnt_ff == 2'h2 |-> !tx_ready_ff)
        else $error("buffer ready while full");
endmodule

/* hdl/sls_pkg.sv */
// constants, types and carriers of the loop-mode secondary station
// What this block does
// - control byte: loop select at bit 1, go active on poll at bit 4
// - status byte: on loop at bit 1, loop sending at bit 4
// - loop select set: receive line passes straight to transmit line
// - loop select also preloads a flag into the transmit shifter
// - stay in pass-through until go active, then search for seven ones
// - seven ones: set break, insert one-bit delay, set on loop, enter hunt
// - on loop: no sending until a flag and a later end of poll arrive
// - with go active, next end of poll becomes a flag, then send
// - at that end of poll set break, hunt and loop sending
// - data ready early gives one flag; otherwise flags until data arrives while go active and loop select stay set
// - go active cleared before last byte: one closing flag, back to delay
// - loop sending clears once the closing flag has been sent
// - go active still set at frame end: keep sending flags
// - underrun and idle settings are ignored while in loop operation
// - control bits belong to software; device never alters them
// - status bits device-driven; command/status bits touched by both sides
// - unimplemented bits read zero; software writes zeros to reserved bits
// - vector read modified with status on second channel only
// - frame byte-count reads give their value only when enabled
// - loop select cleared: finish frame, keep delay, leave at next poll
// - with nrzi add a zero after closing flag if line levels differ
package sls_pkg;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTL_LOOP_SEL = 1;
    localparam int CTL_GO_ACTIVE = 4;
    localparam int STS_ON_LOOP = 1;
    localparam int STS_LOOP_SEND = 4;
    localparam int EXT_BREAK = 7;
    localparam int EXT_HUNT = 4;
    localparam int VEC_STS_LO = 1;
    // ************************************************************
    // bit patterns and reset values
    // ************************************************************
    localparam logic [7:0] FLAG_PAT = 8'h7E;
    localparam logic [7:0] EOP_PAT = 8'h7F;
    localparam logic [6:0] SEVEN_ONES = 7'h7F;
    localparam logic [2:0] STUFF_ONES = 3'h5;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [13:0] FCNT_RST = 14'h0000;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_OFF, ST_PASS, ST_WAIT_FLAG, ST_WAIT_EOP, ST_SEND, ST_PAD
    } sls_state_t;
    typedef struct packed {
        logic on_loop;
        logic loop_sending;
        logic break_abort;
        logic hunt;
    } sls_stat_t;
    localparam sls_stat_t STAT_RST = '{1'b0, 1'b0, 1'b0, 1'b0};
endpackage
